// *** src/slc_regs.sv ***
`timescale 1ns/10ps
`include "slc_map.svh"

// Contract
// - with timestamp enable and sync receiver enable set, timestamp input rides on every output sample LSB
// - timestamp delayed exactly like its sample through the whole path
// - 8-bit modes keep 7 data bits, 12-bit keep 11, mark in LSB
// - control-bits-per-sample announced in lane alignment stays 0
// - link enable resets to 1; write 0 disables, write 1 enables
// - link disabled holds transmitter in reset, serializers down, clocks gated
// - link disabled holds multiframe counter in reset, SYSREF ignored
// - 8-bit link mode field selects operating mode, resets to 0x02
// - only link modes allowed by the mode restriction register are accepted
// - frames-per-multiframe register holds K-1, resets to 0x1F (K=32)
// - in 64b/66b modes K comes from mode as 256*E/F, register ignored
module slc_regs
   import slc_pkg::*;
#(
   parameter int PIPE_DEPTH = `SLC_PIPE_DEPTH
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [13:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [13:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [11:0] sample_in,
   input wire logic sample_in_valid,
   input wire logic sample_8bit_mode,
   input wire logic timestamp_in,
   output logic [11:0] sample_out,
   output logic sample_out_valid,
   input wire logic mode_is_64b66b,
   input wire logic [3:0] mode_e,
   input wire logic [4:0] mode_f,
   input wire logic frame_tick,
   input wire logic sysref,
   output logic [11:0] lmfc_count,
   output logic lmfc_wrap,
   output logic [1:0] ila_cs_out,
   output logic [7:0] link_mode_field,
   output logic [11:0] k_eff_minus_one,
   output logic tx_reset_n,
   output logic serializer_power_down,
   output logic link_clock_enable,
   output logic sync_receiver_enable,
   output logic cal_enable
);

   localparam int AST_LAT = PIPE_DEPTH + 1;

   // ****************************************************************
   // address decode
   // ****************************************************************
   function automatic slc_reg_t slc_decode(input logic [13:0] addr);
      slc_reg_t r;
      r = SLC_REG_NONE;
      if (addr[1:0] == 2'h0) begin
         unique case (addr[13:2])
            `SLC_IDX_MARKER: r = SLC_REG_MARKER;
            `SLC_IDX_ENABLE: r = SLC_REG_ENABLE;
            `SLC_IDX_MODE: r = SLC_REG_MODE;
            `SLC_IDX_KM1: r = SLC_REG_KM1;
            `SLC_IDX_AUX: r = SLC_REG_AUX;
            `SLC_IDX_MLIMIT: r = SLC_REG_MLIMIT;
            `SLC_IDX_STATUS: r = SLC_REG_STATUS;
            `SLC_IDX_KEFF: r = SLC_REG_KEFF;
            default: r = SLC_REG_NONE;
         endcase
      end
      return r;
   endfunction

   function automatic logic [11:0] slc_k64(input logic [3:0] e, input logic [4:0] f);
      logic [12:0] num;
      logic [12:0] quo;
      num = 13'(`SLC_K64_SCALE) * 13'(e);
      quo = (f == 5'h00) ? 13'h0001 : num / 13'(f);
      if (quo == 13'h0000) begin
         quo = 13'h0001;
      end
      return 12'(quo - 13'h0001);
   endfunction

   // ****************************************************************
   // axi4-lite write channel
   // ****************************************************************
   logic aw_hold_q, w_hold_q, bvalid_q;
   logic [13:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   slc_resp_t bresp_q;
   logic wr_fire;
   slc_reg_t wr_sel;

   assign s_axi_awready = !aw_hold_q && !bvalid_q;
   assign s_axi_wready = !w_hold_q && !bvalid_q;
   assign wr_fire = aw_hold_q && w_hold_q;
   assign wr_sel = slc_decode(awaddr_q);
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         awaddr_q <= 14'h0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= SLC_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= (wr_sel == SLC_REG_NONE) ? SLC_RESP_SLVERR : SLC_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // register storage
   // ****************************************************************
   logic [7:0] marker_q, enable_q, mode_q, km1_q, aux_q, mlimit_q;
   logic reject_q;
   logic wr_lane0;
   logic mode_wr, mode_ok;

   assign wr_lane0 = wr_fire && wstrb_q[0];
   assign mode_wr = wr_lane0 && (wr_sel == SLC_REG_MODE);
   assign mode_ok = wdata_q[7:0] <= mlimit_q;

   // reserved bits stored as written, no effect
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         marker_q <= `SLC_RST_MARKER;
         enable_q <= `SLC_RST_ENABLE;
         km1_q <= `SLC_RST_KM1;
         aux_q <= `SLC_RST_AUX;
         mlimit_q <= `SLC_RST_MLIMIT;
      end else if (wr_lane0) begin
         unique case (wr_sel)
            SLC_REG_MARKER: marker_q <= wdata_q[7:0];
            SLC_REG_ENABLE: enable_q <= wdata_q[7:0];
            SLC_REG_KM1: km1_q <= wdata_q[7:0];
            SLC_REG_AUX: aux_q <= wdata_q[7:0];
            SLC_REG_MLIMIT: mlimit_q <= wdata_q[7:0];
            default: ;
         endcase
      end
   end

   // disallowed modes leave the field unchanged
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= `SLC_RST_MODE;
      end else if (mode_wr && mode_ok) begin
         mode_q <= wdata_q[7:0];
      end
   end

   // sticky reject flag, write one to clear, set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reject_q <= 1'b0;
      end else if (mode_wr && !mode_ok) begin
         reject_q <= 1'b1;
      end else if (wr_lane0 && wr_sel == SLC_REG_STATUS && wdata_q[`SLC_BIT_ST_REJ]) begin
         reject_q <= 1'b0;
      end
   end

   // ****************************************************************
   // axi4-lite read channel
   // ****************************************************************
   logic rvalid_q;
   logic [31:0] rdata_q;
   slc_resp_t rresp_q;
   logic [7:0] rd_val;
   slc_reg_t rd_sel;
   logic link_on;

   assign rd_sel = slc_decode(s_axi_araddr);
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_comb begin
      rd_val = 8'h00;
      unique case (rd_sel)
         SLC_REG_MARKER: rd_val = marker_q;
         SLC_REG_ENABLE: rd_val = enable_q;
         SLC_REG_MODE: rd_val = mode_q;
         SLC_REG_KM1: rd_val = km1_q;
         SLC_REG_AUX: rd_val = aux_q;
         SLC_REG_MLIMIT: rd_val = mlimit_q;
         SLC_REG_STATUS: rd_val = {6'h00, reject_q, link_on};
         SLC_REG_KEFF: rd_val = k_eff_minus_one[7:0];
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= SLC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h000000, rd_val};
         rresp_q <= (rd_sel == SLC_REG_NONE) ? SLC_RESP_SLVERR : SLC_RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // link control outputs
   // ****************************************************************
   assign link_on = enable_q[`SLC_BIT_LINK_EN];
   assign tx_reset_n = link_on;
   assign serializer_power_down = !link_on;
   assign link_clock_enable = link_on;
   assign sync_receiver_enable = aux_q[`SLC_BIT_SYNC_EN];
   assign cal_enable = aux_q[`SLC_BIT_CAL_EN];
   assign link_mode_field = mode_q;
   assign ila_cs_out = `SLC_ILA_CS;
   assign k_eff_minus_one = mode_is_64b66b ? slc_k64(mode_e, mode_f) : {4'h0, km1_q};

   // ****************************************************************
   // multiframe counter
   // ****************************************************************
   logic [11:0] lmfc_q;
   logic wrap_q;

   always_ff @(posedge aclk) begin
      if (!aresetn || !link_on) begin
         lmfc_q <= 12'h000;
         wrap_q <= 1'b0;
      end else if (sysref) begin
         lmfc_q <= 12'h000;
         wrap_q <= 1'b0;
      end else if (frame_tick) begin
         wrap_q <= (lmfc_q >= k_eff_minus_one);
         lmfc_q <= (lmfc_q >= k_eff_minus_one) ? 12'h000 : lmfc_q + 12'h001;
      end else begin
         wrap_q <= 1'b0;
      end
   end

   assign lmfc_count = lmfc_q;
   assign lmfc_wrap = wrap_q;

   // ****************************************************************
   // sample path with timestamp mark
   // ****************************************************************
   logic ts_mark;
   logic [14:0] pipe_in, pipe_out;
   logic [11:0] samp_q;
   logic svalid_q;

   // mark only reaches the path through the sync receiver
   assign ts_mark = timestamp_in && marker_q[`SLC_BIT_TS_EN] && sync_receiver_enable;
   assign pipe_in = {sample_in_valid, sample_8bit_mode, ts_mark, sample_in};

   slc_delay #(
      .WIDTH(15),
      .DEPTH(PIPE_DEPTH)
   ) u_delay (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(pipe_in),
      .dout(pipe_out)
   );

   // mark and sample share one delay line
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         samp_q <= 12'h000;
         svalid_q <= 1'b0;
      end else begin
         svalid_q <= pipe_out[14] && link_on;
         if (pipe_out[13]) begin
            samp_q <= {pipe_out[11:5], pipe_out[12], 4'h0};
         end else begin
            samp_q <= {pipe_out[11:1], pipe_out[12]};
         end
      end
   end

   assign sample_out = samp_q;
   assign sample_out_valid = svalid_q;

   // ****************************************************************
   // checks
   // ****************************************************************
   AST_TS_LSB: assert property (@(posedge aclk) disable iff (!aresetn)
      (sample_in_valid && ts_mark && !sample_8bit_mode) |-> ##AST_LAT sample_out[`SLC_BIT_MARK12])
      else $error("timestamp missing on sample lsb");
   AST_TS_ALIGN: assert property (@(posedge aclk) disable iff (!aresetn)
      ##AST_LAT (!sample_8bit_mode || $past(sample_8bit_mode, AST_LAT)) ##0 1'b1 |->
      sample_out[`SLC_BIT_MARK8] == $past(ts_mark, AST_LAT) || !$past(sample_8bit_mode, AST_LAT))
      else $error("timestamp not aligned with its sample");
   AST_W12: assert property (@(posedge aclk) disable iff (!aresetn)
      (!sample_8bit_mode) |-> ##AST_LAT sample_out[11:1] == $past(sample_in[11:1], AST_LAT))
      else $error("12-bit data bits corrupted");
   AST_W8: assert property (@(posedge aclk) disable iff (!aresetn)
      sample_8bit_mode |-> ##AST_LAT
      (sample_out[11:5] == $past(sample_in[11:5], AST_LAT) && sample_out[3:0] == 4'h0))
      else $error("8-bit data bits corrupted");
   AST_ILA_CS: assert property (@(posedge aclk) disable iff (!aresetn)
      ila_cs_out == 2'h0 && $stable(ila_cs_out))
      else $error("control bits announced in alignment sequence");
   AST_EN_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_lane0 && wr_sel == SLC_REG_ENABLE) |=> link_on == $past(wdata_q[0]))
      else $error("link enable write not taken");
   AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      !link_on |-> (!tx_reset_n && serializer_power_down && !link_clock_enable) ##1 !sample_out_valid)
      else $error("transmitter active while link disabled");
   AST_LMFC: assert property (@(posedge aclk) disable iff (!aresetn)
      (!link_on && $past(!link_on)) |-> (lmfc_count == 12'h000 && !lmfc_wrap))
      else $error("multiframe counter runs while link disabled");
   AST_MODE_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_wr && !mode_ok) |=> ($stable(link_mode_field) && reject_q))
      else $error("disallowed link mode accepted");
   AST_MODE_OK: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_wr && mode_ok) |=> link_mode_field == $past(wdata_q[7:0]))
      else $error("allowed link mode not stored");
   AST_K64: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_is_64b66b && mode_f == 5'h04 && mode_e == 4'h1) |-> k_eff_minus_one == 12'h03f)
      else $error("64b66b k not derived from mode");
   AST_KM1: assert property (@(posedge aclk) disable iff (!aresetn)
      !mode_is_64b66b |-> k_eff_minus_one == {4'h0, km1_q})
      else $error("k does not follow register");
   AST_RSV: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_lane0 && wr_sel == SLC_REG_MARKER) |=> marker_q == $past(wdata_q[7:0]))
      else $error("reserved bits not kept");

endmodule

// *** src/slc_map.svh ***
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define SLC_IDX_MARKER   12'h160
`define SLC_IDX_ENABLE   12'h200
`define SLC_IDX_MODE     12'h201
`define SLC_IDX_KM1      12'h202
`define SLC_IDX_AUX      12'h210
`define SLC_IDX_MLIMIT   12'h211
`define SLC_IDX_STATUS   12'h212
`define SLC_IDX_KEFF     12'h213

// ****************************************************************
// reset values
// ****************************************************************
`define SLC_RST_MARKER   8'h00
`define SLC_RST_ENABLE   8'h01
`define SLC_RST_MODE     8'h02
`define SLC_RST_KM1      8'h1f
`define SLC_RST_AUX      8'h00
`define SLC_RST_MLIMIT   8'hff

// ****************************************************************
// field positions
// ****************************************************************
`define SLC_BIT_TS_EN    0
`define SLC_BIT_LINK_EN  0
`define SLC_BIT_SYNC_EN  0
`define SLC_BIT_CAL_EN   1
`define SLC_BIT_ST_LINK  0
`define SLC_BIT_ST_REJ   1
`define SLC_BIT_MARK12   0
`define SLC_BIT_MARK8    4

// ****************************************************************
// timing and misc
// ****************************************************************
`define SLC_PIPE_DEPTH   4
`define SLC_K64_SCALE    256
`define SLC_ILA_CS       2'h0

`endif

// *** src/slc_pkg.sv ***
package slc_pkg;

   typedef enum logic [1:0] {
      SLC_RESP_OKAY   = 2'b00,
      SLC_RESP_SLVERR = 2'b10
   } slc_resp_t;

   typedef enum logic [3:0] {
      SLC_REG_NONE   = 4'b0000,
      SLC_REG_MARKER = 4'b0001,
      SLC_REG_ENABLE = 4'b0010,
      SLC_REG_MODE   = 4'b0011,
      SLC_REG_KM1    = 4'b0100,
      SLC_REG_AUX    = 4'b0101,
      SLC_REG_MLIMIT = 4'b0110,
      SLC_REG_STATUS = 4'b0111,
      SLC_REG_KEFF   = 4'b1000
   } slc_reg_t;

endpackage

// *** src/slc_delay.sv ***
`timescale 1ns/10ps

module slc_delay #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage_q [DEPTH];

   // ****************************************************************
   // fixed-latency shift line
   // ****************************************************************
   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_stage
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               stage_q[i] <= '0;
            end else if (i == 0) begin
               stage_q[i] <= din;
            end else begin
               stage_q[i] <= stage_q[(i == 0) ? 0 : i-1];
            end
         end
      end
   endgenerate

   assign dout = stage_q[DEPTH-1];

endmodule

// *** dv/slc_link_rx.sv ***
`timescale 1ns/10ps

// ****************************************************************
// receiver side: strips the mark from each arriving sample
// ****************************************************************
module slc_link_rx (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] rx_sample,
   input wire logic rx_valid,
   input wire logic rx_8bit,
   output logic [11:0] rx_data,
   output logic rx_mark,
   output logic [7:0] rx_count
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_data <= 12'h000;
         rx_mark <= 1'b0;
         rx_count <= 8'h00;
      end else if (rx_valid) begin
         // mark sits in the sample lsb, data keeps the rest
         rx_data <= rx_8bit ? {rx_sample[11:5], 5'h00} : {rx_sample[11:1], 1'b0};
         rx_mark <= rx_8bit ? rx_sample[4] : rx_sample[0];
         rx_count <= rx_count + 8'h01;
      end
   end
endmodule

// *** dv/slc_regs_tb.sv ***
`timescale 1ns/10ps
`include "slc_map.svh"

module slc_regs_tb
   import slc_pkg::*;
;
   logic aclk = 0, aresetn = 0;
   logic [13:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0;
   logic [3:0] wstrb = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [11:0] sample_in = 0, sample_out, lmfc_count, k_eff_minus_one, rx_data;
   logic sample_in_valid = 0, sample_8bit_mode = 0, timestamp_in = 0, sample_out_valid;
   logic mode_is_64b66b = 0, frame_tick = 0, sysref = 0, lmfc_wrap, rx_mark;
   logic [3:0] mode_e = 4'h1;
   logic [4:0] mode_f = 5'h01;
   logic [1:0] ila_cs_out;
   logic [7:0] link_mode_field, rx_count;
   logic tx_reset_n, serializer_power_down, link_clock_enable, sync_receiver_enable, cal_enable;
   int n_fail = 0, n_checks = 0;

   always #25 aclk = ~aclk;

   slc_regs #(.PIPE_DEPTH(4)) slc_regs_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sample_in(sample_in), .sample_in_valid(sample_in_valid),
      .sample_8bit_mode(sample_8bit_mode), .timestamp_in(timestamp_in),
      .sample_out(sample_out), .sample_out_valid(sample_out_valid),
      .mode_is_64b66b(mode_is_64b66b), .mode_e(mode_e), .mode_f(mode_f),
      .frame_tick(frame_tick), .sysref(sysref), .lmfc_count(lmfc_count), .lmfc_wrap(lmfc_wrap),
      .ila_cs_out(ila_cs_out), .link_mode_field(link_mode_field),
      .k_eff_minus_one(k_eff_minus_one), .tx_reset_n(tx_reset_n),
      .serializer_power_down(serializer_power_down), .link_clock_enable(link_clock_enable),
      .sync_receiver_enable(sync_receiver_enable), .cal_enable(cal_enable));

   slc_link_rx slc_link_rx_i (.aclk(aclk), .aresetn(aresetn), .rx_sample(sample_out),
      .rx_valid(sample_out_valid), .rx_8bit(sample_8bit_mode), .rx_data(rx_data),
      .rx_mark(rx_mark), .rx_count(rx_count));

   // ****************************************************************
   // checking and closing
   // ****************************************************************
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic hang();
      n_fail++;
      final_report();
   endtask

   // ****************************************************************
   // register bus master
   // ****************************************************************
   task automatic axi_wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic aw_hs, w_hs, b_hs;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge aclk);
         aw_hs = awvalid & awready;
         w_hs = wvalid & wready;
         b_hs = bvalid & bready;
         @(posedge aclk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
         if (b_hs) begin
            bready <= 1'b0;
            chk("bresp", {30'h0, bresp}, {30'h0, er});
            return;
         end
      end
      hang();
   endtask

   task automatic axi_rd(input logic [11:0] idx, input logic [7:0] ed, input logic [1:0] er);
      logic ar_hs;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge aclk);
         ar_hs = arvalid & arready;
         if (rvalid & rready) begin
            chk("rresp", {30'h0, rresp}, {30'h0, er});
            chk("rdata", rdata, {24'h000000, ed});
            @(posedge aclk);
            rready <= 1'b0;
            return;
         end
         @(posedge aclk);
         if (ar_hs) arvalid <= 1'b0;
      end
      hang();
   endtask

   // one sample in; seen=0 expects it to be suppressed
   task automatic send(input logic [11:0] s, input logic b8, input logic ts,
                       input logic [11:0] eo, input logic seen);
      int n;
      @(posedge aclk);
      sample_in <= s;
      sample_8bit_mode <= b8;
      timestamp_in <= ts;
      sample_in_valid <= 1'b1;
      for (n = 1; n <= 8; n++) begin
         @(posedge aclk);
         if (n == 1) sample_in_valid <= 1'b0;
         #1;
         if (sample_out_valid === 1'b1) break;
      end
      if (!seen) begin
         chk("no sample", n, 9);
         return;
      end
      chk("latency", n, 5);
      chk("sample_out", sample_out, eo);
      @(posedge aclk);
      #1;
      chk("rx mark", rx_mark, ts);
      chk("rx data", rx_data, b8 ? {s[11:5], 5'h00} : {s[11:1], 1'b0});
   endtask

   task automatic pulse(input logic is_sysref);
      @(posedge aclk);
      if (is_sysref) sysref <= 1'b1;
      else frame_tick <= 1'b1;
      @(posedge aclk);
      frame_tick <= 1'b0;
      sysref <= 1'b0;
      #1;
   endtask

   task automatic pins(input logic en);
      chk("tx_reset_n", tx_reset_n, en);
      chk("power_down", serializer_power_down, !en);
      chk("clock_enable", link_clock_enable, en);
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      axi_rd(`SLC_IDX_MARKER, 8'h00, SLC_RESP_OKAY);
      axi_rd(`SLC_IDX_ENABLE, 8'h01, SLC_RESP_OKAY);
      axi_rd(`SLC_IDX_MODE, 8'h02, SLC_RESP_OKAY);
      axi_rd(`SLC_IDX_KM1, 8'h1f, SLC_RESP_OKAY);
      chk("k_eff", k_eff_minus_one, 12'h01f);
      chk("mode pins", link_mode_field, 8'h02);
      pins(1'b1);
      $display("test reset done");
   endtask

   task automatic t_rsvd();
      axi_wr(`SLC_IDX_MARKER, 8'hfe, SLC_RESP_OKAY);
      axi_rd(`SLC_IDX_MARKER, 8'hfe, SLC_RESP_OKAY);
      axi_wr(12'h001, 8'h55, SLC_RESP_SLVERR);
      axi_rd(12'h001, 8'h00, SLC_RESP_SLVERR);
      axi_wr(`SLC_IDX_MARKER, 8'h00, SLC_RESP_OKAY);
      $display("test reserved done");
   endtask

   task automatic t_disable();
      pulse(1'b0);
      axi_wr(`SLC_IDX_ENABLE, 8'h00, SLC_RESP_OKAY);
      #1;
      pins(1'b0);
      chk("lmfc held", lmfc_count, 12'h000);
      pulse(1'b0);
      pulse(1'b1);
      pulse(1'b0);
      chk("lmfc held", lmfc_count, 12'h000);
      send(12'habc, 1'b0, 1'b1, 12'h000, 1'b0);
      $display("test disable done");
   endtask

   task automatic t_config();
      axi_wr(`SLC_IDX_MLIMIT, 8'h10, SLC_RESP_OKAY);
      axi_wr(`SLC_IDX_MODE, 8'h12, SLC_RESP_OKAY);
      chk("mode refused", link_mode_field, 8'h02);
      axi_rd(`SLC_IDX_STATUS, 8'h02, SLC_RESP_OKAY);
      axi_wr(`SLC_IDX_STATUS, 8'h02, SLC_RESP_OKAY);
      axi_wr(`SLC_IDX_MODE, 8'h05, SLC_RESP_OKAY);
      chk("mode taken", link_mode_field, 8'h05);
      axi_wr(`SLC_IDX_KM1, 8'h03, SLC_RESP_OKAY);
      axi_wr(`SLC_IDX_AUX, 8'h03, SLC_RESP_OKAY);
      chk("sync enable", sync_receiver_enable, 1'b1);
      chk("cal enable", cal_enable, 1'b1);
      axi_wr(`SLC_IDX_MARKER, 8'h01, SLC_RESP_OKAY);
      axi_wr(`SLC_IDX_ENABLE, 8'h01, SLC_RESP_OKAY);
      #1;
      pins(1'b1);
      $display("test config done");
   endtask

   task automatic t_marks();
      send(12'habc, 1'b0, 1'b1, 12'habd, 1'b1);
      send(12'habd, 1'b0, 1'b0, 12'habc, 1'b1);
      send(12'ha40, 1'b1, 1'b1, 12'ha50, 1'b1);
      send(12'ha5f, 1'b1, 1'b0, 12'ha40, 1'b1);
      chk("rx count", rx_count, 8'h04);
      chk("ila cs", ila_cs_out, 2'h0);
      $display("test marks done");
   endtask

   task automatic t_lmfc();
      for (int i = 1; i <= 3; i++) begin
         pulse(1'b0);
         chk("lmfc count", lmfc_count, i);
      end
      chk("no wrap", lmfc_wrap, 1'b0);
      pulse(1'b0);
      chk("lmfc wrapped", lmfc_count, 12'h000);
      chk("wrap pulse", lmfc_wrap, 1'b1);
      pulse(1'b0);
      pulse(1'b1);
      chk("sysref align", lmfc_count, 12'h000);
      @(posedge aclk);
      mode_is_64b66b <= 1'b1;
      mode_e <= 4'h2;
      mode_f <= 5'h04;
      @(posedge aclk);
      #1;
      chk("k 64b66b", k_eff_minus_one, 12'h07f);
      axi_rd(`SLC_IDX_KEFF, 8'h7f, SLC_RESP_OKAY);
      @(posedge aclk);
      mode_e <= 4'h1;
      @(posedge aclk);
      #1;
      chk("k 64b66b", k_eff_minus_one, 12'h03f);
      $display("test lmfc done");
   endtask

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_disable();
      t_rsvd();
      t_config();
      t_marks();
      t_lmfc();
      final_report();
   end
endmodule
